// ===== slsm_mapper.sv
/*
 * Transport-layer sample mapper: places one frame of converter samples
 * onto sixteen serial lane frame words according to the link format.
 * Assumes a downstream link layer that encodes, scrambles and serialises
 * each lane word, octet 0 in bits [31:24], and reads only active lanes.
 */
// Contract
// RULE1: In 8-bit dual-channel 16-lane formats each channel's lane k carries that channel's sample k as one octet.
// RULE2: In decimate-by-4 four-lane formats lane 0 carries in-phase and lane 1 quadrature with flags, per channel.
// RULE3: In decimate-by-4 eight-lane formats lanes 0,1 carry in-phase words 0,1 and lanes 2,3 quadrature words 0,1.
// RULE4: In decimate-by-4 sixteen-lane formats lanes 0-3 carry in-phase words 0-3 and lanes 4-7 quadrature 0-3.
// RULE5: In decimate-by-8 two-lane formats one lane per channel holds in-phase in octets 0,1 and quadrature in 2,3.
// RULE6: In decimate-by-8 four-lane formats lane 0 carries the in-phase word and lane 1 the quadrature word.
// RULE7: In decimate-by-8 eight-lane formats lanes 0,1 carry in-phase words 0,1 and lanes 2,3 quadrature 0,1.
// RULE8: In the decimate-by-8 sixteen-lane format lanes 0-3 carry in-phase 0-3 and lanes 4-7 quadrature 0-3.
// RULE9: In 12-bit bypass twelve-lane formats even samples pack onto first-group lanes 0-5, odd onto second-group.
// RULE10: Each 16-bit complex word holds the sample in bits 15:1 and its over-range flag in bit 0, MSB octet first.
`timescale 1ns/1ps

module slsm_mapper
(
	input wire logic i_mclk,                                   // Frame clock, 25 MHz
	input wire logic i_rst_b,                                  // Synchronous reset, active low
	input wire logic [5:0] i_link_format_select,               // Link format mode number
	input wire logic i_frame_valid,                            // Sample inputs hold a new frame
	input wire logic [7:0][7:0] i_first_channel_octet,         // 8-bit first-channel samples 0..7
	input wire logic [7:0][7:0] i_second_channel_octet,        // 8-bit second-channel samples 0..7
	input wire logic [3:0][14:0] i_first_channel_inphase,      // Complex words 0..3
	input wire logic [3:0][14:0] i_first_channel_quadrature,   // Complex words 0..3
	input wire logic [3:0][14:0] i_second_channel_inphase,     // Complex words 0..3
	input wire logic [3:0][14:0] i_second_channel_quadrature,  // Complex words 0..3
	input wire logic [3:0] i_first_inphase_overrange,          // Flag per in-phase word
	input wire logic [3:0] i_first_quadrature_overrange,       // Flag per quadrature word
	input wire logic [3:0] i_second_inphase_overrange,         // Flag per in-phase word
	input wire logic [3:0] i_second_quadrature_overrange,      // Flag per quadrature word
	input wire logic [15:0][11:0] i_bypass_sample,             // 12-bit single-channel samples 0..15
	output logic [15:0][31:0] o_lane_data,                     // Lane frame words, lanes 8..15 second group
	output logic o_lane_valid,                                 // One cycle per mapped frame
	output logic [15:0] o_lane_active,                         // Lanes in use by the format
	output logic [2:0] o_frame_octets,                         // Octets per lane frame
	output logic o_format_err                                  // Unsupported format selected
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [15:0] cplx_word(input logic [14:0] value, input logic flag);
		cplx_word = {value, flag}; // see RULE10
	endfunction

	function automatic logic [31:0] word_lane(input logic [15:0] word);
		word_lane = {word, 16'h0000}; // see RULE10
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	slsm_pkg::slsm_fmt_e fmt;
	logic [15:0][31:0] lane_r;
	logic [15:0][31:0] lane_nxt;
	logic valid_r;
	logic valid_nxt;
	logic [15:0] active_r;
	logic [15:0] active_nxt;
	logic [2:0] octets_r;
	logic [2:0] octets_nxt;
	logic err_r;
	logic err_nxt;
	logic [7:0][11:0] even_samples;
	logic [7:0][11:0] odd_samples;
	logic [5:0][15:0] even_words;
	logic [5:0][15:0] odd_words;

	// ------------------------------------------------------------------
	// Format decode
	// ------------------------------------------------------------------
	always_comb
	begin
		unique case (i_link_format_select)
			slsm_pkg::LFS_8B_16L_A,
			slsm_pkg::LFS_8B_16L_B:
				fmt = slsm_pkg::FMT_8B_16L;
			slsm_pkg::LFS_D4_4L_A,
			slsm_pkg::LFS_D4_4L_B:
				fmt = slsm_pkg::FMT_D4_4L;
			slsm_pkg::LFS_D4_8L_A,
			slsm_pkg::LFS_D4_8L_B:
				fmt = slsm_pkg::FMT_D4_8L;
			slsm_pkg::LFS_D4_16L_A,
			slsm_pkg::LFS_D4_16L_B:
				fmt = slsm_pkg::FMT_D4_16L;
			slsm_pkg::LFS_D8_2L_A,
			slsm_pkg::LFS_D8_2L_B,
			slsm_pkg::LFS_D8_2L_C,
			slsm_pkg::LFS_D8_2L_D,
			slsm_pkg::LFS_D8_2L_E:
				fmt = slsm_pkg::FMT_D8_2L;
			slsm_pkg::LFS_D8_4L_A,
			slsm_pkg::LFS_D8_4L_B,
			slsm_pkg::LFS_D8_4L_C,
			slsm_pkg::LFS_D8_4L_D:
				fmt = slsm_pkg::FMT_D8_4L;
			slsm_pkg::LFS_D8_8L_A,
			slsm_pkg::LFS_D8_8L_B,
			slsm_pkg::LFS_D8_8L_C:
				fmt = slsm_pkg::FMT_D8_8L;
			slsm_pkg::LFS_D8_16L:
				fmt = slsm_pkg::FMT_D8_16L;
			slsm_pkg::LFS_B12_12L_A,
			slsm_pkg::LFS_B12_12L_B:
				fmt = slsm_pkg::FMT_B12_12L;
			default:
				fmt = slsm_pkg::FMT_NONE;
		endcase
	end

	// ------------------------------------------------------------------
	// Bypass packing: even samples to the first group, odd to the second
	// ------------------------------------------------------------------
	always_comb
	begin
		for (int s = 0; s < 8; s++)
		begin
			even_samples[s] = i_bypass_sample[2 * s];     // see RULE9
			odd_samples[s] = i_bypass_sample[2 * s + 1];  // see RULE9
		end
	end

	slsm_pack12 u_pack_even
	(
		.i_samples(even_samples),
		.o_lane_words(even_words)
	);

	slsm_pack12 u_pack_odd
	(
		.i_samples(odd_samples),
		.o_lane_words(odd_words)
	);

	// ------------------------------------------------------------------
	// Lane mapping
	// ------------------------------------------------------------------
	// Lane words hold their last frame between valid frames so the link
	// layer can sample them late; a format change lands with the next frame.
	always_comb
	begin
		lane_nxt = lane_r;
		active_nxt = active_r;
		octets_nxt = octets_r;
		err_nxt = err_r;
		valid_nxt = 1'b0;
		if (i_frame_valid)
		begin
			lane_nxt = '0;
			active_nxt = slsm_pkg::MASK_RST;
			octets_nxt = slsm_pkg::OCTETS_RST;
			err_nxt = 1'b0;
			valid_nxt = 1'b1;
			unique case (fmt)
				slsm_pkg::FMT_8B_16L:
				begin
					for (int k = 0; k < slsm_pkg::GROUP_LANES; k++)
					begin
						lane_nxt[k] = {i_first_channel_octet[k], 24'h000000}; // see RULE1
						lane_nxt[slsm_pkg::SECOND_GROUP_BASE + k] = {i_second_channel_octet[k], 24'h000000}; // see RULE1
					end
					active_nxt = slsm_pkg::MASK_ALL;
					octets_nxt = slsm_pkg::OCTETS_1;
				end
				slsm_pkg::FMT_D4_4L,
				slsm_pkg::FMT_D8_4L:
				begin
					// Decimate-by-4 and by-8 share this map; see RULE2 and see RULE6
					lane_nxt[0] = word_lane(cplx_word(i_first_channel_inphase[0], i_first_inphase_overrange[0]));
					lane_nxt[1] = word_lane(cplx_word(i_first_channel_quadrature[0], i_first_quadrature_overrange[0]));
					lane_nxt[slsm_pkg::SECOND_GROUP_BASE] =
						word_lane(cplx_word(i_second_channel_inphase[0], i_second_inphase_overrange[0]));
					lane_nxt[slsm_pkg::SECOND_GROUP_BASE + 1] =
						word_lane(cplx_word(i_second_channel_quadrature[0], i_second_quadrature_overrange[0]));
					active_nxt = slsm_pkg::MASK_4L;
					octets_nxt = slsm_pkg::OCTETS_2;
				end
				slsm_pkg::FMT_D4_8L,
				slsm_pkg::FMT_D8_8L:
				begin
					for (int k = 0; k < 2; k++)
					begin
						// In-phase on lanes 0,1 and quadrature on 2,3; see RULE3 and see RULE7
						lane_nxt[k] = word_lane(cplx_word(i_first_channel_inphase[k], i_first_inphase_overrange[k]));
						lane_nxt[2 + k] =
							word_lane(cplx_word(i_first_channel_quadrature[k], i_first_quadrature_overrange[k]));
						lane_nxt[slsm_pkg::SECOND_GROUP_BASE + k] =
							word_lane(cplx_word(i_second_channel_inphase[k], i_second_inphase_overrange[k]));
						lane_nxt[slsm_pkg::SECOND_GROUP_BASE + 2 + k] =
							word_lane(cplx_word(i_second_channel_quadrature[k], i_second_quadrature_overrange[k]));
					end
					active_nxt = slsm_pkg::MASK_8L;
					octets_nxt = slsm_pkg::OCTETS_2;
				end
				slsm_pkg::FMT_D4_16L,
				slsm_pkg::FMT_D8_16L:
				begin
					for (int k = 0; k < 4; k++)
					begin
						// In-phase on lanes 0-3 and quadrature on 4-7; see RULE4 and see RULE8
						lane_nxt[k] = word_lane(cplx_word(i_first_channel_inphase[k], i_first_inphase_overrange[k]));
						lane_nxt[4 + k] =
							word_lane(cplx_word(i_first_channel_quadrature[k], i_first_quadrature_overrange[k]));
						lane_nxt[slsm_pkg::SECOND_GROUP_BASE + k] =
							word_lane(cplx_word(i_second_channel_inphase[k], i_second_inphase_overrange[k]));
						lane_nxt[slsm_pkg::SECOND_GROUP_BASE + 4 + k] =
							word_lane(cplx_word(i_second_channel_quadrature[k], i_second_quadrature_overrange[k]));
					end
					active_nxt = slsm_pkg::MASK_ALL;
					octets_nxt = slsm_pkg::OCTETS_2;
				end
				slsm_pkg::FMT_D8_2L:
				begin
					lane_nxt[0] = {cplx_word(i_first_channel_inphase[0], i_first_inphase_overrange[0]),
						cplx_word(i_first_channel_quadrature[0], i_first_quadrature_overrange[0])}; // see RULE5
					lane_nxt[slsm_pkg::SECOND_GROUP_BASE] =
						{cplx_word(i_second_channel_inphase[0], i_second_inphase_overrange[0]),
						cplx_word(i_second_channel_quadrature[0], i_second_quadrature_overrange[0])}; // see RULE5
					active_nxt = slsm_pkg::MASK_2L;
					octets_nxt = slsm_pkg::OCTETS_4;
				end
				slsm_pkg::FMT_B12_12L:
				begin
					for (int k = 0; k < slsm_pkg::BYPASS_LANES; k++)
					begin
						lane_nxt[k] = word_lane(even_words[k]); // see RULE9
						lane_nxt[slsm_pkg::SECOND_GROUP_BASE + k] = word_lane(odd_words[k]); // see RULE9
					end
					active_nxt = slsm_pkg::MASK_12L;
					octets_nxt = slsm_pkg::OCTETS_2;
				end
				slsm_pkg::FMT_NONE:
				begin
					// Unknown modes send idle zeros rather than a guessed layout
					err_nxt = 1'b1;
					valid_nxt = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			for (int k = 0; k < slsm_pkg::NUM_LANES; k++)
			begin
				lane_r[k] <= slsm_pkg::LANE_RST;
			end
			valid_r <= 1'b0;
			active_r <= slsm_pkg::MASK_RST;
			octets_r <= slsm_pkg::OCTETS_RST;
			err_r <= 1'b0;
		end
		else
		begin
			lane_r <= lane_nxt;
			valid_r <= valid_nxt;
			active_r <= active_nxt;
			octets_r <= octets_nxt;
			err_r <= err_nxt;
		end
	end

	assign o_lane_data = lane_r;
	assign o_lane_valid = valid_r;
	assign o_lane_active = active_r;
	assign o_frame_octets = octets_r;
	assign o_format_err = err_r;

endmodule // slsm_mapper

// ===== slsm_pkg.sv
/*
 * Shared constants and types for the serial lane sample mapper.
 * Assumes one frame of samples arrives per frame-clock cycle and that the
 * link layer downstream takes one lane frame word per lane per cycle.
 */
package slsm_pkg;

	// ------------------------------------------------------------------
	// Lane geometry
	// ------------------------------------------------------------------
	localparam int NUM_LANES = 16;
	localparam int GROUP_LANES = 8;
	localparam int SECOND_GROUP_BASE = 8;
	localparam int LANE_W = 32;
	localparam int BYPASS_LANES = 6;
	localparam int BYPASS_SAMPLES = 16;
	localparam int BYPASS_W = 12;
	localparam int CPLX_W = 15;
	localparam int WORD_W = 16;
	localparam int OCTET_W = 8;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [31:0] LANE_RST = 32'h0000_0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [2:0] OCTETS_RST = 3'h0;

	// ------------------------------------------------------------------
	// Active lane masks and frame lengths in octets
	// ------------------------------------------------------------------
	localparam logic [15:0] MASK_ALL = 16'hFFFF;
	localparam logic [15:0] MASK_2L = 16'h0101;
	localparam logic [15:0] MASK_4L = 16'h0303;
	localparam logic [15:0] MASK_8L = 16'h0F0F;
	localparam logic [15:0] MASK_12L = 16'h3F3F;
	localparam logic [2:0] OCTETS_1 = 3'h1;
	localparam logic [2:0] OCTETS_2 = 3'h2;
	localparam logic [2:0] OCTETS_4 = 3'h4;

	// ------------------------------------------------------------------
	// Link format select codes (6-bit mode numbers)
	// ------------------------------------------------------------------
	localparam logic [5:0] LFS_8B_16L_A = 6'h08;
	localparam logic [5:0] LFS_8B_16L_B = 6'h33;
	localparam logic [5:0] LFS_D4_4L_A = 6'h0A;
	localparam logic [5:0] LFS_D4_4L_B = 6'h25;
	localparam logic [5:0] LFS_D4_8L_A = 6'h0B;
	localparam logic [5:0] LFS_D4_8L_B = 6'h2F;
	localparam logic [5:0] LFS_D4_16L_A = 6'h0C;
	localparam logic [5:0] LFS_D4_16L_B = 6'h35;
	localparam logic [5:0] LFS_D8_2L_A = 6'h0D;
	localparam logic [5:0] LFS_D8_2L_B = 6'h27;
	localparam logic [5:0] LFS_D8_2L_C = 6'h38;
	localparam logic [5:0] LFS_D8_2L_D = 6'h3B;
	// Mode 66 does not fit the 6-bit select; only its low six bits are decoded
	localparam logic [5:0] LFS_D8_2L_E = 6'h02;
	localparam logic [5:0] LFS_D8_4L_A = 6'h0E;
	localparam logic [5:0] LFS_D8_4L_B = 6'h31;
	localparam logic [5:0] LFS_D8_4L_C = 6'h39;
	localparam logic [5:0] LFS_D8_4L_D = 6'h3C;
	localparam logic [5:0] LFS_D8_8L_A = 6'h0F;
	localparam logic [5:0] LFS_D8_8L_B = 6'h37;
	localparam logic [5:0] LFS_D8_8L_C = 6'h3A;
	localparam logic [5:0] LFS_D8_16L = 6'h10;
	localparam logic [5:0] LFS_B12_12L_A = 6'h13;
	localparam logic [5:0] LFS_B12_12L_B = 6'h2A;

	// ------------------------------------------------------------------
	// Decoded format class
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		FMT_NONE = 4'h0,
		FMT_8B_16L = 4'h1,
		FMT_D4_4L = 4'h2,
		FMT_D4_8L = 4'h3,
		FMT_D4_16L = 4'h4,
		FMT_D8_2L = 4'h5,
		FMT_D8_4L = 4'h6,
		FMT_D8_8L = 4'h7,
		FMT_D8_16L = 4'h8,
		FMT_B12_12L = 4'h9
	} slsm_fmt_e;

endpackage

// ===== slsm_pack12.sv
/*
 * Packs eight 12-bit samples contiguously, most significant bits first,
 * into six 16-bit lane words.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps

module slsm_pack12
(
	input wire logic [7:0][11:0] i_samples, // Sample 0 first
	output logic [5:0][15:0] o_lane_words   // Lane word 0 first
);

	logic [95:0] bits;

	// ------------------------------------------------------------------
	// Contiguous packing
	// ------------------------------------------------------------------
	always_comb
	begin
		bits = '0;
		for (int s = 0; s < 8; s++)
		begin
			bits[95 - 12 * s -: 12] = i_samples[s];
		end
		for (int k = 0; k < 6; k++)
		begin
			o_lane_words[k] = bits[95 - 16 * k -: 16];
		end
	end

endmodule // slsm_pack12

// ===== slsm_mapper_assertions.sv
/* Checker for slsm_mapper: frame latency and lane placement.
   Assumes it is bound to slsm_mapper and sees its ports only. */
`timescale 1ns/1ps

module slsm_mapper_assertions
(
	input wire logic i_mclk, // Frame clock
	input wire logic i_rst_b, // Sync reset
	input wire logic [5:0] i_link_format_select, // Mode
	input wire logic i_frame_valid, // Frame strobe
	input wire logic [7:0][7:0] i_first_channel_octet, // 8-bit samples
	input wire logic [3:0][14:0] i_first_channel_inphase, // I words
	input wire logic [3:0][14:0] i_first_channel_quadrature, // Q words
	input wire logic [3:0][14:0] i_second_channel_quadrature, // Q words
	input wire logic [3:0] i_first_inphase_overrange, // I flags
	input wire logic [3:0] i_first_quadrature_overrange, // Q flags
	input wire logic [3:0] i_second_quadrature_overrange, // Q flags
	input wire logic [15:0][11:0] i_bypass_sample, // Bypass samples
	input wire logic [15:0][31:0] o_lane_data, // Lane words
	input wire logic o_lane_valid, // Frame out
	input wire logic [15:0] o_lane_active, // Lane mask
	input wire logic [2:0] o_frame_octets, // Frame length
	input wire logic o_format_err // Bad mode
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	// ------------------------------------------------------------------
	// Frame timing and lane placement
	// ------------------------------------------------------------------
	property p_answer; i_frame_valid |=> (o_lane_valid != o_format_err); endproperty
	a_answer: assert property (p_answer) else $error("frame gave neither valid nor error");
	property p_idle; !i_frame_valid |=> !o_lane_valid; endproperty
	a_idle: assert property (p_idle) else $error("valid without a frame");
	property p_oct; i_frame_valid && i_link_format_select == slsm_pkg::LFS_8B_16L_B |=> o_lane_active ==
		slsm_pkg::MASK_ALL && o_lane_data[7] == {$past(i_first_channel_octet[7]), 24'h000000}; endproperty
	a_oct: assert property (p_oct) else $error("octet lane 7 misplaced");
	property p_d4_4; i_frame_valid && i_link_format_select == slsm_pkg::LFS_D4_4L_A |=> o_lane_data[1] ==
		{$past(i_first_channel_quadrature[0]), $past(i_first_quadrature_overrange[0]), 16'h0000}; endproperty
	a_d4_4: assert property (p_d4_4) else $error("quadrature lane 1 misplaced");
	property p_d4_16; i_frame_valid && i_link_format_select == slsm_pkg::LFS_D4_16L_B |=> o_lane_data[15][31:16] ==
		{$past(i_second_channel_quadrature[3]), $past(i_second_quadrature_overrange[3])}; endproperty
	a_d4_16: assert property (p_d4_16) else $error("lane 15 misplaced");
	property p_d8_2; i_frame_valid && i_link_format_select == slsm_pkg::LFS_D8_2L_A |=> o_lane_data[0] ==
		{$past(i_first_channel_inphase[0]), $past(i_first_inphase_overrange[0]),
		$past(i_first_channel_quadrature[0]), $past(i_first_quadrature_overrange[0])}; endproperty
	a_d8_2: assert property (p_d8_2) else $error("two-lane word misplaced");
	property p_d8_8; i_frame_valid && i_link_format_select == slsm_pkg::LFS_D8_8L_C |=> o_lane_active ==
		slsm_pkg::MASK_8L && o_lane_data[3][31:16] == {$past(i_first_channel_quadrature[1]),
		$past(i_first_quadrature_overrange[1])}; endproperty
	a_d8_8: assert property (p_d8_8) else $error("eight-lane word misplaced");
	property p_byp; i_frame_valid && i_link_format_select == slsm_pkg::LFS_B12_12L_A |=> o_lane_data[0][31:20] ==
		$past(i_bypass_sample[0]) && o_lane_data[8][31:20] == $past(i_bypass_sample[1]); endproperty
	a_byp: assert property (p_byp) else $error("bypass sample misplaced");
	property p_low; o_lane_valid && o_frame_octets == slsm_pkg::OCTETS_2 |-> o_lane_data[0][15:0] == 16'h0000; endproperty
	a_low: assert property (p_low) else $error("unused octets not zero");
endmodule // slsm_mapper_assertions

bind slsm_mapper slsm_mapper_assertions u_chk (.i_mclk, .i_rst_b, .i_link_format_select, .i_frame_valid,
	.i_first_channel_octet, .i_first_channel_inphase, .i_first_channel_quadrature, .i_second_channel_quadrature,
	.i_first_inphase_overrange, .i_first_quadrature_overrange, .i_second_quadrature_overrange, .i_bypass_sample,
	.o_lane_data, .o_lane_valid, .o_lane_active, .o_frame_octets, .o_format_err);

// ===== slsm_link_rx.sv
/* Far-side link receiver model: keeps the last frame on active lanes.
   Assumes the mapper's frame clock and reset. */
`timescale 1ns/1ps

module slsm_link_rx
(
	input wire logic i_mclk, // Frame clock
	input wire logic i_rst_b, // Sync reset, active low
	input wire logic [15:0][31:0] i_lane_data, // Lane words
	input wire logic i_lane_valid, // Frame present
	input wire logic [15:0] i_lane_active, // Lanes in use
	output logic [15:0][31:0] o_rx_word // Last frame received
);
	logic [15:0][31:0] rx_r, rx_nxt;

	// Idle lanes read as zero: a receiver only aligns lanes it was told to use
	always_comb
	begin
		rx_nxt = rx_r;
		for (int k = 0; k < 16; k++)
			if (i_lane_valid)
				rx_nxt[k] = i_lane_active[k] ? i_lane_data[k] : 32'h0000_0000;
	end

	always_ff @(posedge i_mclk)
		rx_r <= i_rst_b ? rx_nxt : '0;

	assign o_rx_word = rx_r;
endmodule // slsm_link_rx

// ===== slsm_mapper_bench.sv
/* Self-checking bench for slsm_mapper with a link receiver model.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps

module slsm_mapper_bench;
	logic clk = 1'b0, rst_b = 1'b0, fv = 1'b0, vld, err;
	logic [5:0] lfs = 6'h00;
	logic [7:0][7:0] oa, ob;
	logic [3:0][14:0] ai, aq, bi, bq;
	logic [3:0] fai, faq, fbi, fbq;
	logic [15:0][11:0] byp;
	logic [15:0][31:0] lane, rx;
	logic [15:0] act;
	logic [2:0] octs;
	int errors = 0, checked = 0;
	logic [5:0] modes [19] = '{6'h0A, 6'h25, 6'h0B, 6'h2F, 6'h0C, 6'h35, 6'h0D, 6'h27, 6'h38, 6'h3B, 6'h02,
		6'h0E, 6'h31, 6'h39, 6'h3C, 6'h0F, 6'h37, 6'h3A, 6'h10};
	int lanes [19] = '{4, 4, 8, 8, 16, 16, 2, 2, 2, 2, 2, 4, 4, 4, 4, 8, 8, 8, 16};

	slsm_mapper DUT (.i_mclk(clk), .i_rst_b(rst_b), .i_link_format_select(lfs), .i_frame_valid(fv),
		.i_first_channel_octet(oa), .i_second_channel_octet(ob), .i_first_channel_inphase(ai),
		.i_first_channel_quadrature(aq), .i_second_channel_inphase(bi), .i_second_channel_quadrature(bq),
		.i_first_inphase_overrange(fai), .i_first_quadrature_overrange(faq), .i_second_inphase_overrange(fbi),
		.i_second_quadrature_overrange(fbq), .i_bypass_sample(byp), .o_lane_data(lane), .o_lane_valid(vld),
		.o_lane_active(act), .o_frame_octets(octs), .o_format_err(err));
	slsm_link_rx RX (.i_mclk(clk), .i_rst_b(rst_b), .i_lane_data(lane), .i_lane_valid(vld), .i_lane_active(act),
		.o_rx_word(rx));

	always #20 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic set_samples(input int s);
		for (int k = 0; k < 16; k++)
		begin
			byp[k] = 12'(k * 12'h2B7 + s * 12'h0F1);
			oa[k % 8] = 8'(k * 8'h13 + s);
			ob[k % 8] = 8'(k * 8'h35 ^ s);
			ai[k % 4] = 15'(k * 15'h1235 + s * 15'h0203);
			aq[k % 4] = ~ai[k % 4] ^ 15'h0F0F;
			bi[k % 4] = ai[k % 4] ^ 15'h5A5A;
			bq[k % 4] = aq[k % 4] + 15'h0333;
		end
		{fai, faq, fbi, fbq} = {4'(s), ~4'(s), 4'(s) ^ 4'h6, 4'(s + 9)};
	endtask

	task automatic frame(input logic [5:0] m, input int s);
		@(negedge clk);
		set_samples(s);
		lfs = m;
		fv = 1'b1;
		@(negedge clk);
		fv = 1'b0;
	endtask

	function automatic logic [15:0] word(input int ch, input int q, input int j);
		if (q)
			return ch ? {bq[j], fbq[j]} : {aq[j], faq[j]};
		return ch ? {bi[j], fbi[j]} : {ai[j], fai[j]};
	endfunction

	function automatic logic [31:0] exp15(input int n, input int ch, input int j);
		int h;
		h = (n == 2) ? 1 : n / 4;
		if (n == 2)
			return (j == 0) ? {word(ch, 0, 0), word(ch, 1, 0)} : 32'h0;
		if (j < 2 * h)
			return {word(ch, j >= h, j % h), 16'h0000};
		return 32'h0;
	endfunction

	task automatic t_octet(input logic [5:0] m, input int s);
		frame(m, s);
		check(32'(act), 32'h0000_FFFF);
		check(32'(octs), 32'h0000_0001);
		for (int k = 0; k < 8; k++)
		begin
			check(lane[k], {oa[k], 24'h000000});
			check(lane[8 + k], {ob[k], 24'h000000});
		end
		@(negedge clk);
		check(rx[15], {ob[7], 24'h000000});
	endtask

	task automatic t_cplx;
		int n;
		for (int t = 0; t < 19; t++)
		begin
			frame(modes[t], t + 10);
			n = lanes[t];
			check(32'(vld), 32'h1);
			check(32'(act), {16'h0000, {2{8'((1 << (n / 2)) - 1)}}});
			check(32'(octs), (n == 2) ? 32'h4 : 32'h2);
			for (int j = 0; j < 8; j++)
			begin
				check(lane[j], exp15(n, 0, j));
				check(lane[8 + j], exp15(n, 1, j));
			end
		end
	endtask

	task automatic t_bypass(input logic [5:0] m, input int s);
		logic [95:0] ev, od;
		frame(m, s);
		for (int k = 0; k < 8; k++)
			{ev, od} = {ev[83:0], byp[2 * k], od[83:0], byp[2 * k + 1]};
		check(32'(act), 32'h0000_3F3F);
		for (int j = 0; j < 8; j++)
		begin
			check(lane[j], (j < 6) ? {ev[95 - 16 * j -: 16], 16'h0000} : 32'h0);
			check(lane[8 + j], (j < 6) ? {od[95 - 16 * j -: 16], 16'h0000} : 32'h0);
		end
	endtask

	task automatic t_b2b;
		@(negedge clk);
		set_samples(7);
		lfs = 6'h0D;
		fv = 1'b1;
		@(negedge clk);
		lfs = 6'h0C;
		check(lane[8], exp15(2, 1, 0));
		@(negedge clk);
		fv = 1'b0;
		check(32'(vld), 32'h1);
		check(lane[13], exp15(16, 1, 5));
	endtask

	task automatic t_bad;
		frame(6'h00, 3);
		check(32'({vld, err, act}), 32'h0001_0000);
		check(lane[0], 32'h0);
		lfs = 6'h08;
		@(negedge clk);
		check(32'({vld, err, act}), 32'h0001_0000);
		frame(6'h10, 4);
		check(32'({vld, err}), 32'h2);
	endtask

	task automatic report_and_stop;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		set_samples(0);
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		t_octet(6'h08, 1);
		t_octet(6'h33, 2);
		t_cplx;
		t_bypass(6'h13, 5);
		t_bypass(6'h2A, 6);
		t_b2b;
		t_bad;
		frame(6'h08, 2);
		rst_b = 1'b0;
		@(negedge clk);
		rst_b = 1'b1;
		check(32'({vld, act}), 32'h0);
		check(lane[0] | rx[0], 32'h0);
		report_and_stop;
	end

	// Whole run is about 60 cycles; this only cuts a hang short
	initial
	begin
		repeat (2000) @(posedge clk);
		errors++;
		report_and_stop;
	end
endmodule // slsm_mapper_bench
